// ### hdl/decode_pkg.sv
// Shared constants and types for the 14-bit instruction decode front end.
// Assumes a single core clock where one clock period is one oscillator period.
package decode_pkg;

    // ==========================================================================
    // Word and field geometry
    // ==========================================================================
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FILE_AW = 7;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int OPC_W = 6;
    localparam int BITNUM_W = 3;

    localparam int CLS_HI = 13;
    localparam int CLS_LO = 12;
    localparam int BYTE_OPC_HI = 13;
    localparam int BYTE_OPC_LO = 8;
    localparam int DEST_POS = 7;
    localparam int FILE_HI = 6;
    localparam int FILE_LO = 0;
    localparam int BIT_OPC_HI = 13;
    localparam int BIT_OPC_LO = 10;
    localparam int BITNUM_HI = 9;
    localparam int BITNUM_LO = 7;
    localparam int LIT8_HI = 7;
    localparam int JUMP_OPC_HI = 13;
    localparam int JUMP_OPC_LO = 11;
    localparam int LIT11_HI = 10;

    // ==========================================================================
    // Encodings and addresses
    // ==========================================================================
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;
    localparam logic DEST_W = 1'h0;
    localparam logic DEST_F = 1'h1;
    localparam logic [OPC_W-1:0] BYTE_CTRL_OPC = 6'h00;
    localparam logic [FILE_AW-1:0] FILE_ADDR_MAX = 7'h7f;
    localparam logic [FILE_AW-1:0] PORT_A_ADDR = 7'h12;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int OSC_PERIOD_NS = 25;
    localparam int OSC_PER_CYCLE = 4;
    localparam int INSTR_CYCLE_NS = OSC_PER_CYCLE * OSC_PERIOD_NS;
    localparam int INSTR_CYCLE_CLKS = INSTR_CYCLE_NS / OSC_PERIOD_NS;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        FMT_BYTE = 2'h0,
        FMT_BIT = 2'h1,
        FMT_LIT = 2'h2,
        FMT_JUMP = 2'h3
    } fmt_t;

    // Gray sequence Q1 -> Q2 -> Q3 -> Q4 so only one bit flips per step.
    typedef enum logic [1:0] {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h3,
        PH_Q4 = 2'h2
    } phase_t;

    // Reset values.
    localparam logic [OPC_W-1:0] OPC_RST = 6'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [LIT11_W-1:0] LIT11_RST = 11'h000;
    localparam logic [FILE_AW-1:0] FILE_RST = 7'h00;
    localparam logic [BITNUM_W-1:0] BITNUM_RST = 3'h0;

endpackage

// ### hdl/decode_if.sv
// Carries one raw instruction word and its decoded fields between modules.
// Assumes the field extractor is purely combinational.
`timescale 1ns/1ps
interface decode_if;
    logic [decode_pkg::INSTR_W-1:0] word;
    decode_pkg::fmt_t fmt;
    logic [decode_pkg::OPC_W-1:0] opcode;
    logic dest_sel;
    logic [decode_pkg::BITNUM_W-1:0] bit_num;
    logic [decode_pkg::FILE_AW-1:0] file_addr;
    logic [decode_pkg::LIT8_W-1:0] lit8;
    logic [decode_pkg::LIT11_W-1:0] lit11;
    logic uses_file;

    modport extract (
        input word,
        output fmt,
        output opcode,
        output dest_sel,
        output bit_num,
        output file_addr,
        output lit8,
        output lit11,
        output uses_file
    );

    modport consume (
        output word,
        input fmt,
        input opcode,
        input dest_sel,
        input bit_num,
        input file_addr,
        input lit8,
        input lit11,
        input uses_file
    );
endinterface

// ### hdl/instr_field_extract.sv
// Combinational classifier and operand extractor for one 14-bit word.
// Assumes the word arrives through the decode interface from the same clock.
`timescale 1ns/1ps
module instr_field_extract (
    decode_if.extract dif
);

    // ==========================================================================
    // Classify first, then pull the fields of that format
    // ==========================================================================
    // Unused fields of a format are forced to zero so nothing downstream
    // ever sees stale operand bits from a different format.
    always_comb begin
        logic [1:0] cls;
        cls = dif.word[decode_pkg::CLS_HI:decode_pkg::CLS_LO];
        dif.fmt = decode_pkg::FMT_BYTE;
        dif.opcode = decode_pkg::OPC_RST;
        dif.dest_sel = decode_pkg::DEST_W;
        dif.bit_num = decode_pkg::BITNUM_RST;
        dif.file_addr = decode_pkg::FILE_RST;
        dif.lit8 = decode_pkg::DATA_RST;
        dif.lit11 = decode_pkg::LIT11_RST;
        dif.uses_file = 1'b0;
        case (cls)
            decode_pkg::CLS_BYTE: begin
                dif.fmt = decode_pkg::FMT_BYTE;
                dif.opcode = dif.word[decode_pkg::BYTE_OPC_HI:decode_pkg::BYTE_OPC_LO];
                dif.dest_sel = dif.word[decode_pkg::DEST_POS];
                dif.file_addr = dif.word[decode_pkg::FILE_HI:decode_pkg::FILE_LO];
                // The all-zero opcode group holds control words that name no file.
                dif.uses_file = !(dif.opcode == decode_pkg::BYTE_CTRL_OPC
                    && dif.dest_sel == decode_pkg::DEST_W);
            end
            decode_pkg::CLS_BIT: begin
                dif.fmt = decode_pkg::FMT_BIT;
                dif.opcode = {2'h0, dif.word[decode_pkg::BIT_OPC_HI:decode_pkg::BIT_OPC_LO]};
                dif.bit_num = dif.word[decode_pkg::BITNUM_HI:decode_pkg::BITNUM_LO];
                dif.file_addr = dif.word[decode_pkg::FILE_HI:decode_pkg::FILE_LO];
                dif.uses_file = 1'b1;
            end
            decode_pkg::CLS_JUMP: begin
                dif.fmt = decode_pkg::FMT_JUMP;
                dif.opcode = {3'h0, dif.word[decode_pkg::JUMP_OPC_HI:decode_pkg::JUMP_OPC_LO]};
                dif.lit11 = dif.word[decode_pkg::LIT11_HI:0];
            end
            decode_pkg::CLS_LIT: begin
                // Don't-care positions inside the opcode pass through untouched;
                // the opcode table outside treats either value the same.
                dif.fmt = decode_pkg::FMT_LIT;
                dif.opcode = dif.word[decode_pkg::BYTE_OPC_HI:decode_pkg::BYTE_OPC_LO];
                dif.lit8 = dif.word[decode_pkg::LIT8_HI:0];
            end
            default: begin
                dif.fmt = decode_pkg::FMT_BYTE;
            end
        endcase
    end

endmodule

// ### hdl/cycle_phase_gen.sv
// Four-phase sequencer that splits each instruction cycle into Q1..Q4.
// Assumes one clock period equals one oscillator period and a synchronised reset.
`timescale 1ns/1ps
module cycle_phase_gen (
    input wire logic clk,
    input wire logic rst_b,
    output decode_pkg::phase_t phase
);

    decode_pkg::phase_t phase_q;
    decode_pkg::phase_t phase_d;

    // ==========================================================================
    // Phase sequence
    // ==========================================================================
    // One instruction cycle is exactly four oscillator periods.
    always_comb begin
        case (phase_q)
            decode_pkg::PH_Q1: phase_d = decode_pkg::PH_Q2;
            decode_pkg::PH_Q2: phase_d = decode_pkg::PH_Q3;
            decode_pkg::PH_Q3: phase_d = decode_pkg::PH_Q4;
            decode_pkg::PH_Q4: phase_d = decode_pkg::PH_Q1;
            default: phase_d = decode_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= decode_pkg::PH_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;

    chk_phase_repeat: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q == decode_pkg::PH_Q1 |-> ##4 phase_q == decode_pkg::PH_Q1)
        else $error("Phase Q1 did not recur after four clocks.");

endmodule

// ### hdl/fourteen_bit_instr_decode.sv
// Top of the instruction decode and timing front end.
// Assumes instr_word, alu_result, op_writes, cond_true and pc_changed come
// from core logic on clk; the opcode table and datapath sit outside.
`timescale 1ns/1ps

module fourteen_bit_instr_decode (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [decode_pkg::INSTR_W-1:0] instr_word,
    input wire logic [decode_pkg::DATA_W-1:0] alu_result,
    input wire logic op_writes,
    input wire logic cond_true,
    input wire logic pc_changed,
    output decode_pkg::phase_t phase,
    output decode_pkg::fmt_t instr_fmt,
    output logic [decode_pkg::OPC_W-1:0] opcode,
    output logic dest_sel,
    output logic [decode_pkg::BITNUM_W-1:0] bit_num,
    output logic [decode_pkg::FILE_AW-1:0] file_addr,
    output logic [decode_pkg::LIT8_W-1:0] lit8,
    output logic [decode_pkg::LIT11_W-1:0] lit11,
    output logic nop_cycle,
    output logic file_rd_en,
    output logic port_a_read,
    output logic file_wr_en,
    output logic w_wr_en,
    output logic [decode_pkg::DATA_W-1:0] wr_data,
    output logic cycle_done
);

    // ==========================================================================
    // Reset release
    // ==========================================================================
    // Assert is immediate; release waits two clocks so no flop leaves reset
    // on a marginal edge.
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ==========================================================================
    // Submodules
    // ==========================================================================
    decode_if dif ();
    decode_pkg::phase_t phase_w;

    assign dif.word = instr_word;

    instr_field_extract u_extract (
        .dif(dif)
    );

    cycle_phase_gen u_phase (
        .clk(clk),
        .rst_b(rst_sync_q),
        .phase(phase_w)
    );

    assign phase = phase_w;

    // ==========================================================================
    // Decoded field latch
    // ==========================================================================
    // Fields are captured at the end of Q4 so they stand for the whole next
    // instruction cycle; the word only has to be valid during Q4.
    decode_pkg::fmt_t fmt_q;
    decode_pkg::fmt_t fmt_d;
    logic [decode_pkg::OPC_W-1:0] opc_q;
    logic [decode_pkg::OPC_W-1:0] opc_d;
    logic dest_q;
    logic dest_d;
    logic [decode_pkg::BITNUM_W-1:0] bitn_q;
    logic [decode_pkg::BITNUM_W-1:0] bitn_d;
    logic [decode_pkg::FILE_AW-1:0] faddr_q;
    logic [decode_pkg::FILE_AW-1:0] faddr_d;
    logic [decode_pkg::LIT8_W-1:0] lit8_q;
    logic [decode_pkg::LIT8_W-1:0] lit8_d;
    logic [decode_pkg::LIT11_W-1:0] lit11_q;
    logic [decode_pkg::LIT11_W-1:0] lit11_d;
    logic uses_file_q;
    logic uses_file_d;
    logic last_phase;

    assign last_phase = (phase_w == decode_pkg::PH_Q4);

    always_comb begin
        fmt_d = fmt_q;
        opc_d = opc_q;
        dest_d = dest_q;
        bitn_d = bitn_q;
        faddr_d = faddr_q;
        lit8_d = lit8_q;
        lit11_d = lit11_q;
        uses_file_d = uses_file_q;
        if (last_phase) begin
            fmt_d = dif.fmt;
            opc_d = dif.opcode;
            dest_d = dif.dest_sel;
            bitn_d = dif.bit_num;
            faddr_d = dif.file_addr;
            lit8_d = dif.lit8;
            lit11_d = dif.lit11;
            uses_file_d = dif.uses_file;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            fmt_q <= decode_pkg::FMT_BYTE;
            opc_q <= decode_pkg::OPC_RST;
            dest_q <= decode_pkg::DEST_W;
            bitn_q <= decode_pkg::BITNUM_RST;
            faddr_q <= decode_pkg::FILE_RST;
            lit8_q <= decode_pkg::DATA_RST;
            lit11_q <= decode_pkg::LIT11_RST;
            uses_file_q <= 1'b0;
        end else begin
            fmt_q <= fmt_d;
            opc_q <= opc_d;
            dest_q <= dest_d;
            bitn_q <= bitn_d;
            faddr_q <= faddr_d;
            lit8_q <= lit8_d;
            lit11_q <= lit11_d;
            uses_file_q <= uses_file_d;
        end
    end

    // ==========================================================================
    // Execution strobes
    // ==========================================================================
    // Strobes are decoded one phase early and registered, so the read stands
    // in Q2 and the store and cycle_done in Q4. A flushed cycle keeps the read and
    // store strobes low, which is what makes it a no-operation; cycle_done still pulses.
    logic nop_q;
    logic nop_d;
    logic rd_q;
    logic rd_d;
    logic port_rd_q;
    logic port_rd_d;
    logic fwr_q;
    logic fwr_d;
    logic wwr_q;
    logic wwr_d;
    logic [decode_pkg::DATA_W-1:0] wdata_q;
    logic [decode_pkg::DATA_W-1:0] wdata_d;
    logic done_q;
    logic done_d;
    logic live;
    logic to_file;
    logic to_w;

    assign live = !nop_q;
    // Bit operations always land in the file; byte operations follow d.
    assign to_file = uses_file_q
        && (fmt_q == decode_pkg::FMT_BIT || dest_q == decode_pkg::DEST_F);
    assign to_w = (fmt_q == decode_pkg::FMT_LIT)
        || (fmt_q == decode_pkg::FMT_BYTE && dest_q == decode_pkg::DEST_W);

    always_comb begin
        nop_d = nop_q;
        rd_d = 1'b0;
        port_rd_d = 1'b0;
        fwr_d = 1'b0;
        wwr_d = 1'b0;
        wdata_d = wdata_q;
        done_d = 1'b0;
        case (phase_w)
            decode_pkg::PH_Q1: begin
                // The read is issued for every file access, even pure writes.
                rd_d = live && uses_file_q;
                port_rd_d = live && uses_file_q
                    && faddr_q == decode_pkg::PORT_A_ADDR;
            end
            decode_pkg::PH_Q2: begin
                nop_d = nop_q;
            end
            decode_pkg::PH_Q3: begin
                fwr_d = live && op_writes && to_file;
                wwr_d = live && op_writes && to_w;
                wdata_d = alu_result;
                done_d = 1'b1;
            end
            decode_pkg::PH_Q4: begin
                // A flushed cycle never flushes the one after it.
                nop_d = live && (cond_true || pc_changed);
            end
            default: begin
                nop_d = nop_q;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            nop_q <= 1'b0;
            rd_q <= 1'b0;
            port_rd_q <= 1'b0;
            fwr_q <= 1'b0;
            wwr_q <= 1'b0;
            wdata_q <= decode_pkg::DATA_RST;
            done_q <= 1'b0;
        end else begin
            nop_q <= nop_d;
            rd_q <= rd_d;
            port_rd_q <= port_rd_d;
            fwr_q <= fwr_d;
            wwr_q <= wwr_d;
            wdata_q <= wdata_d;
            done_q <= done_d;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    assign instr_fmt = fmt_q;
    assign opcode = opc_q;
    assign dest_sel = dest_q;
    assign bit_num = bitn_q;
    assign file_addr = faddr_q;
    assign lit8 = lit8_q;
    assign lit11 = lit11_q;
    assign nop_cycle = nop_q;
    assign file_rd_en = rd_q;
    assign port_a_read = port_rd_q;
    assign file_wr_en = fwr_q;
    assign w_wr_en = wwr_q;
    assign wr_data = wdata_q;
    assign cycle_done = done_q;

    // ==========================================================================
    // Checks
    // ==========================================================================
    chk_byte_fields: assert property (@(posedge clk) disable iff (!rst_sync_q)
        last_phase && instr_word[13:12] == 2'h0 |=> fmt_q == decode_pkg::FMT_BYTE
        && opc_q == $past(instr_word[13:8]) && dest_q == $past(instr_word[7])
        && faddr_q == $past(instr_word[6:0]))
        else $error("Byte format fields mis-extracted.");

    chk_bit_fields: assert property (@(posedge clk) disable iff (!rst_sync_q)
        last_phase && instr_word[13:12] == 2'h1 |=> fmt_q == decode_pkg::FMT_BIT
        && opc_q == {2'h0, $past(instr_word[13:10])} && bitn_q == $past(instr_word[9:7])
        && faddr_q == $past(instr_word[6:0]))
        else $error("Bit format fields mis-extracted.");

    chk_lit_fields: assert property (@(posedge clk) disable iff (!rst_sync_q)
        last_phase && instr_word[13:12] == 2'h3 |=> fmt_q == decode_pkg::FMT_LIT
        && opc_q == $past(instr_word[13:8]) && lit8_q == $past(instr_word[7:0]))
        else $error("Literal format fields mis-extracted.");

    chk_jump_fields: assert property (@(posedge clk) disable iff (!rst_sync_q)
        last_phase && instr_word[13:12] == 2'h2 |=> fmt_q == decode_pkg::FMT_JUMP
        && opc_q == {3'h0, $past(instr_word[13:11])} && lit11_q == $past(instr_word[10:0]))
        else $error("Jump format fields mis-extracted.");

    chk_fields_hold: assert property (@(posedge clk) disable iff (!rst_sync_q)
        !last_phase |=> $stable(fmt_q) && $stable(opc_q) && $stable(faddr_q))
        else $error("Decoded fields changed inside a cycle.");

    chk_dest_route: assert property (@(posedge clk) disable iff (!rst_sync_q)
        w_wr_en |-> !file_wr_en && (fmt_q == decode_pkg::FMT_LIT || dest_q == 1'b0))
        else $error("Working register written against destination select.");

    chk_cycle_len: assert property (@(posedge clk) disable iff (!rst_sync_q)
        cycle_done |=> !cycle_done [*3] ##1 cycle_done)
        else $error("Instruction cycle is not four clocks.");

    chk_nop_quiet: assert property (@(posedge clk) disable iff (!rst_sync_q)
        cycle_done && !nop_q && (cond_true || pc_changed) |=> nop_q throughout
        (!file_rd_en && !file_wr_en && !w_wr_en) [*4])
        else $error("Second cycle did not execute as a no-operation.");

    chk_read_first: assert property (@(posedge clk) disable iff (!rst_sync_q)
        file_wr_en |-> $past(file_rd_en, 2))
        else $error("File store without its preceding read.");

    chk_port_read: assert property (@(posedge clk) disable iff (!rst_sync_q)
        port_a_read |-> file_rd_en && faddr_q == decode_pkg::PORT_A_ADDR
        && phase_w == decode_pkg::PH_Q2)
        else $error("Port read strobe out of step with file read.");

    chk_addr_range: assert property (@(posedge clk) disable iff (!rst_sync_q)
        file_rd_en |-> faddr_q <= decode_pkg::FILE_ADDR_MAX && phase_w == decode_pkg::PH_Q2
        && (fmt_q == decode_pkg::FMT_BYTE || fmt_q == decode_pkg::FMT_BIT))
        else $error("File read outside Q2 or address range.");

endmodule

// ### test/testbench.sv
// ============================================================================
// Self-checking bench for the 14-bit instruction decode front end.
// Drives the top module's ports directly; expectations come from bench functions.
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst_b;
    logic [13:0] instr_word;
    logic [7:0] alu_result;
    logic op_writes;
    logic cond_true;
    logic pc_changed;
    decode_pkg::phase_t phase;
    decode_pkg::fmt_t instr_fmt;
    logic [5:0] opcode;
    logic dest_sel;
    logic [2:0] bit_num;
    logic [6:0] file_addr;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic nop_cycle, file_rd_en, port_a_read, file_wr_en, w_wr_en, cycle_done;
    logic [7:0] wr_data;
    int n_fail = 0;
    int n_checks = 0;

    fourteen_bit_instr_decode u_fourteen_bit_instr_decode (
        .clk(clk), .rst_b(rst_b), .instr_word(instr_word), .alu_result(alu_result),
        .op_writes(op_writes), .cond_true(cond_true), .pc_changed(pc_changed),
        .phase(phase), .instr_fmt(instr_fmt), .opcode(opcode), .dest_sel(dest_sel),
        .bit_num(bit_num), .file_addr(file_addr), .lit8(lit8), .lit11(lit11),
        .nop_cycle(nop_cycle), .file_rd_en(file_rd_en), .port_a_read(port_a_read),
        .file_wr_en(file_wr_en), .w_wr_en(w_wr_en), .wr_data(wr_data),
        .cycle_done(cycle_done));

    // ========================================================================
    // Clock, watchdog and shared helpers.
    // ========================================================================
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The run needs about 820 cycles; the margin covers a slow reset release.
    initial begin
        repeat (1500) @(posedge clk);
        n_fail++;
        results();
    end

    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Packs fmt, opcode, dest, bit number, file address, lit8 and lit11.
    function automatic logic [37:0] exp_fields(logic [13:0] w);
        case (w[13:12])
            2'h0: return {2'h0, w[13:8], w[7], 3'h0, w[6:0], 8'h00, 11'h000};
            2'h1: return {2'h1, 2'h0, w[13:10], 1'h0, w[9:7], w[6:0], 8'h00, 11'h000};
            2'h2: return {2'h3, 3'h0, w[13:11], 1'h0, 3'h0, 7'h00, 8'h00, w[10:0]};
            default: return {2'h2, w[13:8], 1'h0, 3'h0, 7'h00, w[7:0], 11'h000};
        endcase
    endfunction

    // A control word with opcode zero and destination W names no file.
    function automatic logic uses_file(logic [13:0] w);
        return (w[13:12] == 2'h1) || (w[13:12] == 2'h0 && (w[13:8] != 6'h00 || w[7]));
    endfunction

    // ========================================================================
    // Main sequence: one loop pass per instruction cycle, sampled at falling edges.
    // ========================================================================
    initial begin
        logic [13:0] corner [8];
        logic [13:0] cw, nw;
        logic [7:0] calu, nalu;
        logic [1:0] nk;
        logic cwr, nwr, cfl, cnop, ef, ew, rd;
        corner = '{14'h0192, 14'h0005, 14'h17ff, 14'h2abc, 14'h3fa5, 14'h0e7f,
                   14'h1812, 14'h0000};
        void'($urandom(29));
        rst_b = 1'b0;
        instr_word = 14'h0000;
        alu_result = 8'h00;
        op_writes = 1'b0;
        cond_true = 1'b0;
        pc_changed = 1'b0;
        cw = 14'h0000;
        {calu, cwr, cfl, cnop} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        do @(negedge clk); while (phase !== decode_pkg::PH_Q3);
        for (int i = 0; i < 200; i++) begin
            nw = (i < 8) ? corner[i] : 14'($urandom);
            nalu = 8'($urandom);
            nwr = (i < 8) ? 1'b1 : 1'($urandom);
            nk = (i == 3 || i == 4) ? 2'h3 : 2'($urandom);
            // Third oscillator period: no strobes.
            check("phase", phase, decode_pkg::PH_Q3);
            check("cycle_done q3", cycle_done, 1'b0);
            @(posedge clk);
            instr_word <= nw;
            @(negedge clk);
            ef = uses_file(cw) && cwr && !cnop && (cw[13:12] == 2'h1 || cw[7]);
            ew = cwr && !cnop && (cw[13:12] == 2'h3 || (cw[13:12] == 2'h0 && !cw[7]));
            check("phase", phase, decode_pkg::PH_Q4);
            check("cycle_done", cycle_done, 1'b1);
            check("file_wr_en", file_wr_en, ef);
            check("w_wr_en", w_wr_en, ew);
            if (ef || ew) begin
                check("wr_data", wr_data, calu);
            end
            @(posedge clk);
            alu_result <= nalu;
            op_writes <= nwr;
            cond_true <= nk[0];
            pc_changed <= nk[1];
            // A flushed cycle never flushes the one after it.
            cnop = cfl && !cnop;
            cw = nw;
            calu = nalu;
            cwr = nwr;
            cfl = (nk != 2'h0);
            @(negedge clk);
            check("phase", phase, decode_pkg::PH_Q1);
            check("fields", {instr_fmt, opcode, dest_sel, bit_num, file_addr, lit8, lit11},
                  exp_fields(cw));
            check("nop_cycle", nop_cycle, cnop);
            @(negedge clk);
            rd = uses_file(cw) && !cnop;
            check("phase", phase, decode_pkg::PH_Q2);
            check("file_rd_en", file_rd_en, rd);
            check("port_a_read", port_a_read, rd && cw[6:0] == 7'h12);
            @(negedge clk);
        end
        results();
    end
endmodule
